// ===== include/ccp_pkg.sv
// Shared constants and types for the capture unit
package ccp_pkg;
   // Register offsets on the plain register port
   localparam int ADDR_W = 3;
   localparam logic [2:0] OFF_CONTROL = 3'h0;
   localparam logic [2:0] OFF_CAP_LOW = 3'h1;
   localparam logic [2:0] OFF_CAP_HIGH = 3'h2;
   localparam logic [2:0] OFF_FLAG = 3'h3;
   localparam logic [2:0] OFF_ENABLE = 3'h4;

   // Control register layout
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 3;
   localparam int DUTY_LSB = 4;
   localparam int DUTY_MSB = 5;
   localparam int CTRL_W = 6;
   localparam logic [5:0] CTRL_RESET = 6'h00;
   localparam int FLAG_BIT = 0;
   localparam int ENABLE_BIT = 0;
   localparam logic [15:0] CAP_RESET = 16'h0000;

   // Mode field encodings used by the capture half
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_FALL = 4'h4;
   localparam logic [3:0] MODE_RISE = 4'h5;
   localparam logic [3:0] MODE_RISE4 = 4'h6;
   localparam logic [3:0] MODE_RISE16 = 4'h7;
   localparam logic [1:0] CAPTURE_GROUP = 2'h1;

   // Prescaler terminal counts
   localparam int PRE_W = 4;
   localparam logic [3:0] PRE_RESET = 4'h0;
   localparam logic [3:0] DIV4_LAST = 4'h3;
   localparam logic [3:0] DIV16_LAST = 4'hf;

   typedef enum logic [1:0] {DIV_1, DIV_4, DIV_16} ccp_div_e;
   typedef enum logic [1:0] {EV_NONE, EV_FALL, EV_RISE} ccp_event_e;
endpackage

// ===== logic/ccp_capture_unit.sv
// Capture half of the capture/compare/PWM unit with its register port
`timescale 1ns/1ps
module ccp_capture_unit
#(
   parameter bit SECOND_UNIT = 1'b1
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [15:0] timebase_counter,
   input wire logic timer_capture_ok,
   input wire logic capture_pin,
   input wire logic second_unit_pin,
   input wire logic pin_select,
   output logic capture_irq,
   output logic capture_strobe,
   output logic [15:0] captured_value,
   output logic [3:0] unit_mode_field,
   output logic [1:0] duty_low_bits
);
   typedef struct packed
   {
      logic [5:0] control;
      logic [7:0] captured_count_high;
      logic [7:0] captured_count_low;
      logic capture_event_flag;
      logic capture_event_enable;
      logic [7:0] rdata;
      logic strobe;
   } ccp_state_s;

   ccp_state_s st;
   ccp_state_s next_st;

   logic pin_level;
   logic pin_rise;
   logic pin_fall;
   logic [3:0] mode;
   logic in_capture;
   logic pre_clear;
   logic pre_edge;
   logic pre_fire;
   logic capture;
   logic wr_control;
   logic wr_low;
   logic wr_high;
   logic wr_flag;
   logic wr_enable;
   logic [7:0] rd_value;
   ccp_pkg::ccp_div_e div_sel;
   ccp_pkg::ccp_event_e ev_sel;

   assign mode = st.control[ccp_pkg::MODE_MSB:ccp_pkg::MODE_LSB];

   // The pad level is used whatever the pin direction, so port writes can trigger
   assign pin_level = (SECOND_UNIT && pin_select) ? second_unit_pin : capture_pin;

   ccp_pin_sync u_sync
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .pin_in(pin_level),
      .rise(pin_rise),
      .fall(pin_fall)
   );

   // Event and ratio selection from the mode field
   always_comb
   begin
      ev_sel = ccp_pkg::EV_NONE;
      div_sel = ccp_pkg::DIV_1;
      case (mode)
         ccp_pkg::MODE_FALL:
         begin
            ev_sel = ccp_pkg::EV_FALL;
         end
         ccp_pkg::MODE_RISE:
         begin
            ev_sel = ccp_pkg::EV_RISE;
         end
         ccp_pkg::MODE_RISE4:
         begin
            ev_sel = ccp_pkg::EV_RISE;
            div_sel = ccp_pkg::DIV_4;
         end
         ccp_pkg::MODE_RISE16:
         begin
            ev_sel = ccp_pkg::EV_RISE;
            div_sel = ccp_pkg::DIV_16;
         end
         default:
         begin
            ev_sel = ccp_pkg::EV_NONE;
            div_sel = ccp_pkg::DIV_1;
         end
      endcase
   end

   assign in_capture = (mode[3:2] == ccp_pkg::CAPTURE_GROUP);
   // Mode zero and every non-capture mode hold the prescaler at zero
   assign pre_clear = ~in_capture | (mode == ccp_pkg::MODE_OFF);

   // The synchroniser is not cleared on a mode write, so a pending edge may land
   // under the new mode as one spurious capture
   always_comb
   begin
      pre_edge = 1'b0;
      case (ev_sel)
         ccp_pkg::EV_RISE:
         begin
            pre_edge = pin_rise;
         end
         ccp_pkg::EV_FALL:
         begin
            pre_edge = pin_fall;
         end
         default:
         begin
            pre_edge = 1'b0;
         end
      endcase
   end

   ccp_prescaler #(.CNT_W(ccp_pkg::PRE_W)) u_pre
   (
      .clock(clock),
      .sys_rst(sys_rst),
      .clear(pre_clear),
      .edge_in(pre_edge),
      .div_sel(div_sel),
      .fire(pre_fire)
   );

   // Unsupported timer clocking is reported by the timer and suppresses capture
   assign capture = pre_fire & timer_capture_ok;

   // One decoder for all writes; unmapped offsets hit nothing
   always_comb
   begin
      wr_control = 1'b0;
      wr_low = 1'b0;
      wr_high = 1'b0;
      wr_flag = 1'b0;
      wr_enable = 1'b0;
      if (reg_wr)
      begin
         case (reg_addr)
            ccp_pkg::OFF_CONTROL:
            begin
               wr_control = 1'b1;
            end
            ccp_pkg::OFF_CAP_LOW:
            begin
               wr_low = 1'b1;
            end
            ccp_pkg::OFF_CAP_HIGH:
            begin
               wr_high = 1'b1;
            end
            ccp_pkg::OFF_FLAG:
            begin
               wr_flag = 1'b1;
            end
            ccp_pkg::OFF_ENABLE:
            begin
               wr_enable = 1'b1;
            end
            default:
            begin
               wr_control = 1'b0;
            end
         endcase
      end
   end

   // Unmapped offsets read as zero so software sees no stale byte
   always_comb
   begin
      rd_value = 8'h00;
      case (reg_addr)
         ccp_pkg::OFF_CONTROL:
         begin
            rd_value = {2'h0, st.control};
         end
         ccp_pkg::OFF_CAP_LOW:
         begin
            rd_value = st.captured_count_low;
         end
         ccp_pkg::OFF_CAP_HIGH:
         begin
            rd_value = st.captured_count_high;
         end
         ccp_pkg::OFF_FLAG:
         begin
            rd_value = {7'h00, st.capture_event_flag};
         end
         ccp_pkg::OFF_ENABLE:
         begin
            rd_value = {7'h00, st.capture_event_enable};
         end
         default:
         begin
            rd_value = 8'h00;
         end
      endcase
   end

   always_comb
   begin
      next_st = st;
      next_st.strobe = capture;

      if (wr_control)
      begin
         next_st.control = reg_wdata[ccp_pkg::CTRL_W-1:0];
      end

      // Software may preload the pair; a capture in the same cycle wins
      if (wr_low)
      begin
         next_st.captured_count_low = reg_wdata;
      end
      if (wr_high)
      begin
         next_st.captured_count_high = reg_wdata;
      end
      if (capture)
      begin
         // Always overwritten; there is no overrun flag to tell it happened
         next_st.captured_count_high = timebase_counter[15:8];
         next_st.captured_count_low = timebase_counter[7:0];
      end

      // Write one to clear; a capture in the same cycle keeps the flag set
      if (wr_flag && reg_wdata[ccp_pkg::FLAG_BIT])
      begin
         next_st.capture_event_flag = 1'b0;
      end
      if (capture)
      begin
         next_st.capture_event_flag = 1'b1;
      end

      if (wr_enable)
      begin
         next_st.capture_event_enable = reg_wdata[ccp_pkg::ENABLE_BIT];
      end

      // Read data stands for the cycle after the strobe only
      next_st.rdata = reg_rd ? rd_value : 8'h00;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st.control <= ccp_pkg::CTRL_RESET;
         st.captured_count_high <= ccp_pkg::CAP_RESET[15:8];
         st.captured_count_low <= ccp_pkg::CAP_RESET[7:0];
         st.capture_event_flag <= 1'b0;
         st.capture_event_enable <= 1'b0;
         st.rdata <= 8'h00;
         st.strobe <= 1'b0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign capture_irq = st.capture_event_flag & st.capture_event_enable;
   assign capture_strobe = st.strobe;
   assign captured_value = {st.captured_count_high, st.captured_count_low};
   assign unit_mode_field = mode;
   assign duty_low_bits = st.control[ccp_pkg::DUTY_MSB:ccp_pkg::DUTY_LSB];
endmodule

// ===== logic/ccp_pin_sync.sv
// Pin synchroniser with rise and fall detection
`timescale 1ns/1ps
module ccp_pin_sync
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic pin_in,
   output logic rise,
   output logic fall
);
   typedef struct packed
   {
      logic s1;
      logic s2;
      logic s3;
   } ccp_sync_s;

   ccp_sync_s st;
   ccp_sync_s next_st;

   always_comb
   begin
      next_st = st;
      next_st.s1 = pin_in;
      next_st.s2 = st.s1;
      next_st.s3 = st.s2;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   // Only the settled stages are compared, never the first one
   assign rise = st.s2 & ~st.s3;
   assign fall = ~st.s2 & st.s3;
endmodule

// ===== logic/ccp_prescaler.sv
// Edge prescaler: passes every 1st, 4th or 16th edge
`timescale 1ns/1ps
module ccp_prescaler
#(
   parameter int CNT_W = ccp_pkg::PRE_W
)
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic clear,
   input wire logic edge_in,
   input wire ccp_pkg::ccp_div_e div_sel,
   output logic fire
);
   typedef struct packed
   {
      logic [CNT_W-1:0] cnt;
   } ccp_pre_s;

   ccp_pre_s st;
   ccp_pre_s next_st;
   logic [CNT_W-1:0] last;
   logic at_last;

   assign last = (div_sel == ccp_pkg::DIV_4) ? CNT_W'(ccp_pkg::DIV4_LAST)
                                             : CNT_W'(ccp_pkg::DIV16_LAST);
   assign at_last = (st.cnt == last);

   always_comb
   begin
      next_st = st;
      if (clear)
      begin
         next_st.cnt = CNT_W'(ccp_pkg::PRE_RESET);
      end
      else if (edge_in && div_sel != ccp_pkg::DIV_1)
      begin
         // A count left over from another ratio is kept, so a switch may fire early
         next_st.cnt = at_last ? '0 : st.cnt + 1'b1;
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end

   assign fire = edge_in & ~clear & ((div_sel == ccp_pkg::DIV_1) | at_last);
endmodule

// ===== tb/ccp_cap_monitor.sv
// Port checker for the capture unit
`timescale 1ns/1ps
module ccp_cap_monitor
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [15:0] timebase_counter,
   input wire logic timer_capture_ok,
   input wire logic capture_pin,
   input wire logic second_unit_pin,
   input wire logic pin_select,
   input wire logic capture_irq,
   input wire logic capture_strobe,
   input wire logic [15:0] captured_value,
   input wire logic [3:0] unit_mode_field
);
   wire sel_pin = pin_select ? second_unit_pin : capture_pin;
   default clocking @(posedge clock);
   endclocking
   default disable iff (sys_rst);
   cap_value_a: assert property (capture_strobe |->
      captured_value == $past(timebase_counter)) else $error("wrong captured value");
   cap_mode_a: assert property (capture_strobe |->
      unit_mode_field[3:2] == 2'h1) else $error("capture outside capture modes");
   // Three sync stages put the pad change four samples back
   pin_edge_a: assert property (capture_strobe |->
      $past(sel_pin, 3) != $past(sel_pin, 4) &&
      $past(sel_pin, 3) == (unit_mode_field != ccp_pkg::MODE_FALL))
      else $error("capture without matching edge");
   irq_rise_a: assert property ($rose(capture_irq) |->
      capture_strobe || $past(capture_strobe) || $past(reg_wr) || $past(reg_wr, 2))
      else $error("irq rose without cause");
   irq_sticky_a: assert property ($fell(capture_irq) |->
      $past(reg_wr) || $past(reg_wr, 2)) else $error("irq dropped by itself");
   timer_gate_a: assert property ((!timer_capture_ok)[*4] |->
      !capture_strobe) else $error("capture with unsupported timer");
   strobe_one_a: assert property (capture_strobe |=> !capture_strobe)
      else $error("strobe longer than one cycle");
   mode_write_a: assert property ($past(reg_wr && reg_addr == ccp_pkg::OFF_CONTROL) |->
      unit_mode_field == $past(reg_wdata[3:0])) else $error("mode not taken");
   ctrl_top_a: assert property ($past(reg_rd && reg_addr == ccp_pkg::OFF_CONTROL) |->
      reg_rdata[7:6] == 2'h0) else $error("control top bits not zero");
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data outside read slot");
   cover property (capture_strobe && unit_mode_field == ccp_pkg::MODE_RISE16);
   cover property (capture_strobe && pin_select);
   cover property ($fell(capture_irq));
endmodule
bind ccp_capture_unit ccp_cap_monitor mon (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .timebase_counter, .timer_capture_ok, .capture_pin, .second_unit_pin,
   .pin_select, .capture_irq, .capture_strobe, .captured_value, .unit_mode_field);

// ===== tb/ccp_pin_source.sv
// Signal source model driving the capture pads
`timescale 1ns/1ps
module ccp_pin_source
(
   input wire logic clock,
   input wire logic use_alt,
   output logic pad_main,
   output logic pad_alt
);
   logic level = 1'b0;
   logic noise = 1'b0;
   // Unused pad toggles so a wrong route shows up as extra captures
   always @(posedge clock)
      noise <= ~noise;
   assign pad_main = use_alt ? noise : level;
   assign pad_alt = use_alt ? level : noise;
   task automatic pulses(input int n);
      repeat (n)
      begin
         level <= 1'b1;
         repeat (2) @(posedge clock);
         level <= 1'b0;
         repeat (4) @(posedge clock);
      end
   endtask
endmodule

// ===== tb/tb.sv
// Self-checking bench for the capture unit
`timescale 1ns/1ps
module tb;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic timer_capture_ok = 1'b1;
   logic pin_select = 1'b0;
   logic [15:0] timebase_counter = 16'h0000;
   logic [15:0] prev_count = 16'h0000;
   logic [15:0] exp_cap = 16'h0000;
   logic [7:0] reg_rdata;
   logic capture_pin, second_unit_pin, capture_irq, capture_strobe;
   logic [15:0] captured_value;
   logic [3:0] unit_mode_field;
   logic [1:0] duty_low_bits;
   int errors = 0;
   int compares = 0;
   int strobes = 0;
   ccp_capture_unit uut (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .timebase_counter, .timer_capture_ok, .capture_pin, .second_unit_pin, .pin_select,
      .capture_irq, .capture_strobe, .captured_value, .unit_mode_field, .duty_low_bits);
   ccp_pin_source src (.clock, .use_alt(pin_select), .pad_main(capture_pin),
      .pad_alt(second_unit_pin));
   always #50 clock = ~clock;
   // Timer steps every cycle so a capture one cycle off is caught
   always @(posedge clock)
   begin
      timebase_counter <= timebase_counter + 16'h0001;
      prev_count <= timebase_counter;
      if (capture_strobe === 1'b1)
      begin
         exp_cap <= prev_count;
         strobes <= strobes + 1;
      end
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want)
      begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [2:0] a, input logic [15:0] want);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(negedge clock);
      check({8'h00, reg_rdata}, want);
      @(posedge clock);
   endtask
   task automatic irq_is(input logic want);
      @(negedge clock);
      check({15'h0000, capture_irq}, {15'h0000, want});
      @(posedge clock);
   endtask
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic run(input logic [3:0] m1, input int n1, input logic [3:0] m2, input int n2,
      input logic ok, input logic sel, input int want);
      int base;
      wr(ccp_pkg::OFF_ENABLE, 8'h00);
      wr(ccp_pkg::OFF_CONTROL, 8'h00);
      timer_capture_ok <= ok;
      pin_select <= sel;
      repeat (4) @(posedge clock);
      base = strobes;
      wr(ccp_pkg::OFF_CONTROL, {4'h0, m1});
      wr(ccp_pkg::OFF_FLAG, 8'h01);
      wr(ccp_pkg::OFF_ENABLE, 8'h01);
      src.pulses(n1);
      wr(ccp_pkg::OFF_CONTROL, {4'h0, m2});
      src.pulses(n2);
      repeat (6) @(posedge clock);
      check(16'(strobes - base), 16'(want));
      if (want > 0)
      begin
         rd(ccp_pkg::OFF_FLAG, 16'h0001);
         rd(ccp_pkg::OFF_CAP_LOW, {8'h00, exp_cap[7:0]});
         rd(ccp_pkg::OFF_CAP_HIGH, {8'h00, exp_cap[15:8]});
         check(captured_value, exp_cap);
         irq_is(1'b1);
         wr(ccp_pkg::OFF_ENABLE, 8'h00);
         irq_is(1'b0);
         rd(ccp_pkg::OFF_FLAG, 16'h0001);
         wr(ccp_pkg::OFF_ENABLE, 8'h01);
         irq_is(1'b1);
         wr(ccp_pkg::OFF_FLAG, 8'h01);
         irq_is(1'b0);
      end
      $display("Run ending in mode %h done", m2);
   endtask
   initial
   begin
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd(ccp_pkg::OFF_CONTROL, 16'h0000);
      rd(ccp_pkg::OFF_CAP_LOW, 16'h0000);
      wr(3'h5, 8'hff);
      rd(3'h5, 16'h0000);
      wr(ccp_pkg::OFF_CONTROL, 8'hff);
      rd(ccp_pkg::OFF_CONTROL, 16'h003f);
      check({14'h0000, duty_low_bits}, 16'h0003);
      check({12'h000, unit_mode_field}, 16'h000f);
      $display("Register test done");
      run(ccp_pkg::MODE_FALL, 8, ccp_pkg::MODE_FALL, 8, 1'b1, 1'b0, 16);
      run(ccp_pkg::MODE_RISE, 8, ccp_pkg::MODE_RISE, 8, 1'b1, 1'b0, 16);
      run(ccp_pkg::MODE_RISE4, 8, ccp_pkg::MODE_RISE4, 8, 1'b1, 1'b0, 4);
      run(ccp_pkg::MODE_RISE16, 8, ccp_pkg::MODE_RISE16, 8, 1'b1, 1'b0, 1);
      run(ccp_pkg::MODE_RISE4, 2, ccp_pkg::MODE_RISE16, 14, 1'b1, 1'b0, 1);
      run(ccp_pkg::MODE_RISE4, 2, ccp_pkg::MODE_RISE4, 0, 1'b1, 1'b0, 0);
      run(ccp_pkg::MODE_RISE4, 3, ccp_pkg::MODE_RISE4, 0, 1'b1, 1'b0, 0);
      run(ccp_pkg::MODE_RISE, 4, ccp_pkg::MODE_RISE, 4, 1'b0, 1'b0, 0);
      run(ccp_pkg::MODE_RISE, 3, ccp_pkg::MODE_RISE, 2, 1'b1, 1'b1, 5);
      close_out;
   end
   initial
   begin
      repeat (20000) @(posedge clock);
      errors++;
      close_out;
   end
endmodule
